/* File: design/acc_control.sv */
// Control logic for a pair of analog comparators: modes, start-up, flags, events
//
// Behaviour
// R1: Settings captured at enable, frozen while enabled
// R2: Per-comparator enable bit turns comparator on/off
// R3: Module enable off stops all, keeps bits
// R4: Single-shot select: zero continuous, one single
// R5: Start-up delay before any result appears
// R6: Interrupt on toggle, rise, fall or end
// R7: End-of-comparison interrupt fires every comparison
// R8: Events follow output state, ignore interrupt enable
// R9: Continuous: compare, update state, ready, events
// R10: Continuous repeats; start-up only before first
// R11: Continuous edges from successive clocked samples
// R12: Sleep continuous: request clock on state change
// R13: Single-shot: start bit runs exactly one comparison
// R14: Software start clears ready; completion sets it
// R15: Enabled input event starts single-shot comparison
// R16: Event start leaves ready bit unchanged
// R17: Single-shot edges compare against previous measurement
// R18: Sleep event start requests clock for comparison
// R19: Positive selects pins; negative pins or references
// R20: Software changes inputs only while disabled
// R21: Software sets output routing for custom logic; this block has no routing output
// R22: Filter none, majority of three or five
// R23: Interrupt request while flag and enable set
// R24: Disable aborts comparison, keeps last result
module acc_control #(
  parameter int STARTUP_CYCLES = acc_pkg::ACC_STARTUP_CYCLES
) (
  input  wire logic                                              ref_clk,
  input  wire logic                                              sys_rst,
  input  wire logic                                              moduleEnable,
  input  wire logic [acc_pkg::ACC_NUM_COMP-1:0]                  compEnable,
  input  wire logic [acc_pkg::ACC_NUM_COMP-1:0]                  singleShot,
  input  wire acc_pkg::acc_irq_sel_t [acc_pkg::ACC_NUM_COMP-1:0] irqConditionSelect,
  input  wire acc_pkg::acc_flt_t [acc_pkg::ACC_NUM_COMP-1:0]     filterLength,
  input  wire logic [acc_pkg::ACC_NUM_COMP-1:0][acc_pkg::ACC_POS_W-1:0] positiveInputSelect,
  input  wire logic [acc_pkg::ACC_NUM_COMP-1:0][acc_pkg::ACC_NEG_W-1:0] negativeInputSelect,
  input  wire logic [acc_pkg::ACC_NUM_COMP-1:0]                  runInStandby,
  input  wire logic [acc_pkg::ACC_NUM_COMP-1:0]                  startComparison,
  input  wire logic [acc_pkg::ACC_NUM_COMP-1:0]                  eventStartEnable,
  input  wire logic [acc_pkg::ACC_NUM_COMP-1:0]                  startEvent,
  input  wire logic [acc_pkg::ACC_NUM_COMP-1:0]                  eventOutEnable,
  input  wire logic [acc_pkg::ACC_NUM_COMP-1:0]                  irqEnable,
  input  wire logic [acc_pkg::ACC_NUM_COMP-1:0]                  irqFlagClear,
  input  wire logic                                              sleepMode,
  input  wire logic                                              wakeupEnable,
  input  wire logic [acc_pkg::ACC_NUM_COMP-1:0]                  rawCompOut,
  output logic [acc_pkg::ACC_NUM_COMP-1:0]                       comparatorState,
  output logic [acc_pkg::ACC_NUM_COMP-1:0]                       comparatorReady,
  output logic [acc_pkg::ACC_NUM_COMP-1:0]                       compEvent,
  output logic [acc_pkg::ACC_NUM_COMP-1:0]                       irqFlag,
  output logic                                                   irqRequest,
  output logic [acc_pkg::ACC_NUM_COMP-1:0]                       compPowerUp,
  output logic [acc_pkg::ACC_NUM_COMP-1:0][acc_pkg::ACC_POS_W-1:0] posSelectOut,
  output logic [acc_pkg::ACC_NUM_COMP-1:0][acc_pkg::ACC_NEG_W-1:0] negSelectOut,
  output logic                                                   clockRequest
);
  import acc_pkg::*;

  localparam int NC = ACC_NUM_COMP;

  // Refuse start-up counts the counter cannot hold
  if (STARTUP_CYCLES < 1 || STARTUP_CYCLES >= 2 ** ACC_CNT_W) begin : g_chk
    $error("STARTUP_CYCLES out of range for the phase counter");
  end

  typedef struct packed {
    logic [NC-1:0]                  syncA;
    logic [NC-1:0]                  syncB;
    logic [NC-1:0]                  active;
    acc_phase_t [NC-1:0]            phase;
    logic [NC-1:0][ACC_CNT_W-1:0]   count;
    logic [NC-1:0]                  single;
    acc_irq_sel_t [NC-1:0]          irqSel;
    acc_flt_t [NC-1:0]              flt;
    logic [NC-1:0][ACC_POS_W-1:0]   posSel;
    logic [NC-1:0][ACC_NEG_W-1:0]   negSel;
    logic [NC-1:0]                  runStby;
    logic [NC-1:0]                  state;
    logic [NC-1:0]                  ready;
    logic [NC-1:0]                  evOut;
    logic [NC-1:0]                  flag;
    logic [NC-1:0]                  powerUp;
    logic                           irqReq;
    logic                           clkReq;
  } acc_regs_t;

  acc_regs_t     stReg;
  acc_regs_t     stNext;
  logic [NC-1:0] doneVec;
  logic [NC-1:0] startAcc;
  logic [NC-1:0] evtAcc;
  logic [NC-1:0] sampleEn;
  logic [NC-1:0] fltClear;
  logic [NC-1:0] majority;
  logic [NC-1:0] needClk;

  // Edge and end-of-comparison match for the selected condition
  function automatic logic irq_hit(input acc_irq_sel_t sel, input logic prev,
                                   input logic now);
    case (sel)
      ACC_IRQ_TOGGLE: return prev != now;
      ACC_IRQ_RISE:   return !prev && now;
      ACC_IRQ_FALL:   return prev && !now;
      default:        return 1'b1;
    endcase
  endfunction : irq_hit

  // One majority filter per comparator, fed from the synchronised output
  for (genvar g = 0; g < NC; g++) begin : g_flt
    acc_majority_filter u_flt (
      .ref_clk      (ref_clk),
      .sys_rst      (sys_rst),
      .clear        (fltClear[g]),
      .sampleEn     (sampleEn[g]),
      .sample       (stReg.syncB[g]),
      .filterLength (stReg.flt[g]),
      .majority     (majority[g])
    );
  end

  // Next-state logic for both comparators
  always_comb begin
    logic                 act;
    logic [ACC_CNT_W-1:0] nSamp;
    act      = 1'b0;
    nSamp    = '0;
    stNext   = stReg;
    doneVec  = '0;
    startAcc = '0;
    evtAcc   = '0;
    sampleEn = '0;
    fltClear = '0;
    needClk  = '0;
    // Analog output is asynchronous, so two stages before use
    stNext.syncA = rawCompOut;
    stNext.syncB = stReg.syncA;
    for (int i = 0; i < NC; i++) begin
      // Module enable gates without touching the per-comparator bit
      act = moduleEnable && compEnable[i] && (!sleepMode || stReg.runStby[i]); // see R2 see R3
      stNext.active[i] = act;
      nSamp = acc_samples(stReg.flt[i]);
      // Settings only follow the inputs while the comparator is off
      if (!stReg.active[i]) begin // see R1
        stNext.single[i]  = singleShot[i];
        stNext.irqSel[i]  = irqConditionSelect[i];
        stNext.flt[i]     = filterLength[i];
        stNext.posSel[i]  = positiveInputSelect[i]; // see R19
        stNext.negSel[i]  = negativeInputSelect[i]; // see R19
        stNext.runStby[i] = runInStandby[i];
      end
      // Filter history only collects samples of a running comparison
      sampleEn[i] = (stReg.phase[i] == ACC_SAMPLE && stReg.count[i] < nSamp) ||
                    stReg.phase[i] == ACC_RUN;
      fltClear[i] = stReg.phase[i] == ACC_IDLE || stReg.phase[i] == ACC_STARTUP;
      if (!act) begin
        // Abort anything in progress; last result stays in place
        stNext.phase[i] = ACC_IDLE; // see R24
        stNext.count[i] = '0;
      end else begin
        case (stReg.phase[i])
          ACC_IDLE: begin
            if (!stReg.active[i]) begin
              // Fresh enable: one cycle to settle the captured settings
              stNext.phase[i] = ACC_IDLE;
            end else if (!stReg.single[i]) begin
              stNext.phase[i] = ACC_STARTUP; // see R4 see R10
            end else if (startComparison[i]) begin
              startAcc[i]     = 1'b1; // see R13
              stNext.phase[i] = ACC_STARTUP;
            end else if (eventStartEnable[i] && startEvent[i]) begin
              evtAcc[i]       = 1'b1; // see R15 see R18
              stNext.phase[i] = ACC_STARTUP;
            end
            stNext.count[i] = '0;
          end
          ACC_STARTUP: begin
            // No sample is taken until the delay has run out
            if (stReg.count[i] == ACC_CNT_W'(STARTUP_CYCLES - 1)) begin // see R5
              stNext.phase[i] = ACC_SAMPLE;
              stNext.count[i] = '0;
            end else begin
              stNext.count[i] = stReg.count[i] + 1'b1;
            end
          end
          ACC_SAMPLE: begin
            if (stReg.count[i] == nSamp) begin
              doneVec[i]      = 1'b1;
              stNext.phase[i] = stReg.single[i] ? ACC_IDLE : ACC_RUN; // see R13 see R10
              stNext.count[i] = '0;
            end else begin
              stNext.count[i] = stReg.count[i] + 1'b1;
            end
          end
          default: begin
            // Continuous: a result every clock from the sliding window
            doneVec[i] = 1'b1; // see R10 see R11
          end
        endcase
      end
      // Result, edge against the previous result, and flags
      if (doneVec[i]) begin
        stNext.state[i] = majority[i]; // see R9
      end
      if (startAcc[i]) begin
        stNext.ready[i] = 1'b0; // see R14 see R16
      end
      if (doneVec[i]) begin
        stNext.ready[i] = 1'b1; // see R9 see R14
      end
      if (irqFlagClear[i]) begin
        stNext.flag[i] = 1'b0;
      end
      // Set beats a clear in the same cycle so no event is lost
      if (doneVec[i] && irq_hit(stReg.irqSel[i], stReg.state[i], majority[i])) begin
        stNext.flag[i] = 1'b1; // see R6 see R7 see R17
      end
      // Event output copies the state whatever the interrupt enable
      stNext.evOut[i]   = eventOutEnable[i] && stNext.state[i]; // see R8
      stNext.powerUp[i] = act && stNext.phase[i] != ACC_IDLE;
      // Clock is needed to finish a shot or register an output change
      needClk[i] = evtAcc[i] || startAcc[i] ||
                   stReg.phase[i] == ACC_STARTUP || stReg.phase[i] == ACC_SAMPLE ||
                   (stReg.phase[i] == ACC_RUN && stReg.syncB[i] != stReg.state[i]) ||
                   stReg.flag[i] != stNext.flag[i];
    end
    stNext.irqReq = |(stNext.flag & irqEnable); // see R23
    // In sleep the clock is held while work is pending or wake-up is enabled
    stNext.clkReq = !sleepMode || wakeupEnable || |needClk; // see R12 see R18
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stReg <= '0;
    end else begin
      stReg <= stNext;
    end
  end

  // Outputs straight from the state register
  assign comparatorState = stReg.state;
  assign comparatorReady = stReg.ready;
  assign compEvent       = stReg.evOut;
  assign irqFlag         = stReg.flag;
  assign irqRequest      = stReg.irqReq;
  assign compPowerUp     = stReg.powerUp;
  assign posSelectOut    = stReg.posSel;
  assign negSelectOut    = stReg.negSel;
  assign clockRequest    = stReg.clkReq;

  // Checks on comparator 0; comparator 1 shares the same logic
  localparam int ShotMin = STARTUP_CYCLES + 1;
  localparam int ShotMax = STARTUP_CYCLES + 8;

  default clocking acc_cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence shot_start_s;
    startAcc[0] ##1 (stReg.phase[0] == ACC_STARTUP);
  endsequence

  sequence startup_enter_s;
    $rose(stReg.phase[0] == ACC_STARTUP);
  endsequence

  cfg_lock_a: assert property ( // see R1
    stReg.active[0] && $past(stReg.active[0]) |-> $stable(stReg.posSel[0]) &&
      $stable(stReg.single[0]) && $stable(stReg.flt[0]) && $stable(stReg.irqSel[0]))
    else $error("comparator settings changed while enabled");

  module_off_a: assert property ( // see R3
    !moduleEnable |=> !compPowerUp[0] && stReg.phase[0] == ACC_IDLE)
    else $error("comparator kept running with module disabled");

  startup_quiet_a: assert property ( // see R5
    startup_enter_s |-> (!doneVec[0] && $stable(stReg.state[0])) [*8])
    else $error("result produced during start-up");

  single_shot_a: assert property ( // see R13
    shot_start_s |-> ##[ShotMin:ShotMax] (doneVec[0] || !stReg.active[0]))
    else $error("single-shot comparison did not complete in time");

  shot_once_a: assert property ( // see R13
    doneVec[0] && stReg.single[0] |=> stReg.phase[0] == ACC_IDLE ##1 !doneVec[0])
    else $error("single-shot ran more than one comparison");

  eoc_irq_a: assert property ( // see R7
    doneVec[0] && stReg.irqSel[0] == ACC_IRQ_EOC |=> irqFlag[0])
    else $error("end-of-comparison flag missing");

  ready_set_a: assert property ( // see R9
    doneVec[0] |=> comparatorReady[0] && comparatorState[0] == $past(majority[0]))
    else $error("ready or state not updated on completion");

  start_clear_a: assert property ( // see R14
    startAcc[0] |=> !comparatorReady[0])
    else $error("software start did not clear ready");

  event_ready_a: assert property ( // see R16
    evtAcc[0] |=> comparatorReady[0] == $past(comparatorReady[0]))
    else $error("event start changed ready");

  event_follow_a: assert property ( // see R8
    compEvent[0] == ($past(eventOutEnable[0]) && comparatorState[0]))
    else $error("event output does not follow state");

  irq_req_a: assert property ( // see R23
    irqRequest == |(irqFlag & $past(irqEnable)))
    else $error("interrupt request does not match flags and enables");

  abort_keep_a: assert property ( // see R24
    $fell(stReg.active[0]) |-> stReg.phase[0] == ACC_IDLE && $stable(comparatorState[0]))
    else $error("disable did not abort or lost the last result");

  // Idle, repeat and flag paths
  idle_hold_a: assert property ( // see R13 see R15
    stReg.single[0] && stReg.phase[0] == ACC_IDLE && !startComparison[0] &&
      !eventStartEnable[0] |=> stReg.phase[0] == ACC_IDLE && !compPowerUp[0])
    else $error("single-shot left idle without a start");

  run_repeat_a: assert property ( // see R10
    stReg.phase[0] == ACC_RUN && stNext.active[0] |-> doneVec[0] ##1 stReg.phase[0] == ACC_RUN)
    else $error("continuous comparisons stopped while enabled");

  rise_flag_a: assert property ( // see R11 see R17
    doneVec[0] && stReg.irqSel[0] == ACC_IRQ_RISE && !stReg.state[0] && majority[0]
      |=> irqFlag[0])
    else $error("rising result did not set the flag");

  fall_flag_a: assert property ( // see R6 see R17
    doneVec[0] && stReg.irqSel[0] == ACC_IRQ_FALL && stReg.state[0] && !majority[0]
      |=> irqFlag[0])
    else $error("falling result did not set the flag");

  flag_clear_a: assert property ( // see R23
    irqFlagClear[0] && !doneVec[0] |=> !irqFlag[0])
    else $error("flag clear was not applied");

  state_hold_a: assert property ( // see R24
    !doneVec[0] |=> $stable(comparatorState[0]))
    else $error("state changed without a comparison");

  ready_hold_a: assert property ( // see R16
    !doneVec[0] && !startAcc[0] |=> $stable(comparatorReady[0]))
    else $error("ready changed without a start or result");

endmodule : acc_control

/* File: design/acc_majority_filter.sv */
// Majority vote output filter for one comparator
module acc_majority_filter (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             clear,
  input  wire logic             sampleEn,
  input  wire logic             sample,
  input  wire acc_pkg::acc_flt_t filterLength,
  output logic                  majority
);
  import acc_pkg::*;

  typedef struct packed {
    logic [ACC_HIST_W-1:0] hist;
  } acc_flt_state_t;

  acc_flt_state_t fltReg;
  acc_flt_state_t fltNext;

  // True when at least N/2+1 of the last N samples are one
  function automatic logic vote(input logic [ACC_HIST_W-1:0] h, input acc_flt_t len);
    logic [ACC_HIST_W-1:0] m;
    logic [2:0]            ones;
    logic [2:0]            need;
    m    = (len == ACC_FLT_MAJ3) ? ACC_MASK_3 :
           (len == ACC_FLT_MAJ5) ? ACC_MASK_5 : ACC_MASK_1;
    ones = 3'h0;
    need = 3'(acc_samples(len) >> 1) + 3'h1;
    for (int k = 0; k < ACC_HIST_W; k++) begin
      ones = ones + {2'h0, h[k] & m[k]};
    end
    return ones >= need;
  endfunction : vote

  // History shifts on each sample; cleared while no comparison runs
  always_comb begin
    fltNext = fltReg;
    if (clear) begin
      fltNext.hist = ACC_HIST_RST;
    end else if (sampleEn) begin
      fltNext.hist = {fltReg.hist[ACC_HIST_W-2:0], sample}; // see R22
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fltReg <= '0;
    end else begin
      fltReg <= fltNext;
    end
  end

  // Vote over the stored history only
  assign majority = vote(fltReg.hist, filterLength); // see R22

endmodule : acc_majority_filter

/* File: design/acc_pkg.sv */
// Shared constants and types for the analog comparator control block
package acc_pkg;

  // Comparator count and field widths
  localparam int ACC_NUM_COMP = 2;
  localparam int ACC_POS_W    = 2;
  localparam int ACC_NEG_W    = 3;
  localparam int ACC_CNT_W    = 9;
  localparam int ACC_HIST_W   = 5;

  // Clock period and start-up delay, cycle count rounded up
  localparam int ACC_CLK_PERIOD_PS   = 5000;
  localparam int ACC_STARTUP_TIME_NS = 1000;
  localparam int ACC_STARTUP_CYCLES  =
    (ACC_STARTUP_TIME_NS * 1000 + ACC_CLK_PERIOD_PS - 1) / ACC_CLK_PERIOD_PS;

  // Values after reset
  localparam logic ACC_STATE_RST = 1'b0;
  localparam logic ACC_READY_RST = 1'b0;
  localparam logic [ACC_HIST_W-1:0] ACC_HIST_RST = 5'h00;

  // Filter masks over the sample history, newest sample in bit 0
  localparam logic [ACC_HIST_W-1:0] ACC_MASK_1 = 5'h01;
  localparam logic [ACC_HIST_W-1:0] ACC_MASK_3 = 5'h07;
  localparam logic [ACC_HIST_W-1:0] ACC_MASK_5 = 5'h1F;

  // Interrupt condition select
  typedef enum logic [1:0] {
    ACC_IRQ_TOGGLE,
    ACC_IRQ_RISE,
    ACC_IRQ_FALL,
    ACC_IRQ_EOC
  } acc_irq_sel_t;

  // Output filter length; the reserved code behaves as no filter
  typedef enum logic [1:0] {
    ACC_FLT_NONE,
    ACC_FLT_MAJ3,
    ACC_FLT_MAJ5,
    ACC_FLT_RSVD
  } acc_flt_t;

  // Per-comparator measurement phase
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_STARTUP,
    ACC_SAMPLE,
    ACC_RUN
  } acc_phase_t;

  // Number of samples a comparison takes for a filter length
  function automatic logic [ACC_CNT_W-1:0] acc_samples(input acc_flt_t len);
    case (len)
      ACC_FLT_MAJ3: return 9'h003;
      ACC_FLT_MAJ5: return 9'h005;
      default:      return 9'h001;
    endcase
  endfunction : acc_samples

endpackage : acc_pkg

/* File: dv/acc_comp_model.sv */
// Behavioural model of the two analog comparator cores behind the control block
module acc_comp_model #(
  parameter int SETTLE = 3
) (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] powerUp,
  input  wire logic [1:0] analogLevel,
  output logic      [1:0] rawOut
);
  // Results feed only the control block here; the routing code is software's
  int settleCnt [2];

  // An unpowered or still settling core gives no usable level, so it toggles
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rawOut    <= 2'h0;
      settleCnt <= '{0, 0};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!powerUp[i]) begin
          settleCnt[i] <= 0;
        end else if (settleCnt[i] < SETTLE) begin
          settleCnt[i] <= settleCnt[i] + 1;
        end
        rawOut[i] <= (powerUp[i] && settleCnt[i] >= SETTLE) ? analogLevel[i] : ~rawOut[i];
      end
    end
  end
endmodule : acc_comp_model

/* File: dv/testbench.sv */
// Self-checking testbench for the comparator control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import acc_pkg::*;

  localparam int S     = 8;
  localparam int LIMIT = 6000;

  logic                      ref_clk, sys_rst, moduleEnable, sleepMode, wakeupEnable;
  logic [1:0]                compEnable, singleShot, runInStandby, startComparison;
  logic [1:0]                eventStartEnable, startEvent, eventOutEnable, irqEnable;
  logic [1:0]                irqFlagClear, rawCompOut, analogLevel, expState;
  acc_irq_sel_t [1:0]        irqSel;
  acc_flt_t [1:0]            fltLen;
  logic [1:0][ACC_POS_W-1:0] posSel, posOut;
  logic [1:0][ACC_NEG_W-1:0] negSel, negOut;
  logic [1:0]                compState, compReady, compEvent, irqFlag, compPowerUp;
  logic                      irqRequest, clockRequest;
  int                        failCount, numChecks, cycles, seed, n;

  acc_control #(.STARTUP_CYCLES(S)) DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .moduleEnable(moduleEnable),
    .compEnable(compEnable), .singleShot(singleShot), .irqConditionSelect(irqSel),
    .filterLength(fltLen), .positiveInputSelect(posSel), .negativeInputSelect(negSel),
    .runInStandby(runInStandby), .startComparison(startComparison),
    .eventStartEnable(eventStartEnable), .startEvent(startEvent),
    .eventOutEnable(eventOutEnable), .irqEnable(irqEnable), .irqFlagClear(irqFlagClear),
    .sleepMode(sleepMode), .wakeupEnable(wakeupEnable), .rawCompOut(rawCompOut),
    .comparatorState(compState), .comparatorReady(compReady), .compEvent(compEvent),
    .irqFlag(irqFlag), .irqRequest(irqRequest), .compPowerUp(compPowerUp),
    .posSelectOut(posOut), .negSelectOut(negOut), .clockRequest(clockRequest)
  );

  acc_comp_model #(.SETTLE(3)) cores (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .powerUp(compPowerUp),
    .analogLevel(analogLevel), .rawOut(rawCompOut)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic completeRun();
    if (failCount == 0 && numChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : completeRun

  // Flag a comparison should raise, from the previous and the new result
  function automatic logic expFlag(input int k, input logic p, input logic v);
    case (k)
      0:       return p ^ v;
      1:       return !p && v;
      2:       return p && !v;
      default: return 1'b1;
    endcase
  endfunction : expFlag

  function automatic int samples(input acc_flt_t f);
    return (f == ACC_FLT_MAJ3) ? 3 : (f == ACC_FLT_MAJ5) ? 5 : 1;
  endfunction : samples

  task automatic waitState(input int c, input logic v, output int cnt);
    cnt = 0;
    while (compState[c] !== v && cnt < 60) begin
      @(negedge ref_clk);
      cnt++;
    end
  endtask : waitState

  // Settings move only while the comparator is off, then it is enabled again
  task automatic setup(input int c, input logic single, input int k, input int f,
                       input logic stby);
    @(posedge ref_clk);
    compEnable[c] <= 1'b0;
    @(posedge ref_clk);
    singleShot[c]   <= single;
    irqSel[c]       <= acc_irq_sel_t'(k);
    fltLen[c]       <= acc_flt_t'(f);
    runInStandby[c] <= stby;
    posSel[c]       <= ACC_POS_W'($random(seed));
    negSel[c]       <= ACC_NEG_W'($random(seed));
    irqEnable       <= 2'($random(seed));
    eventOutEnable  <= 2'($random(seed));
    @(posedge ref_clk);
    compEnable[c] <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    check("state kept", compState[c], expState[c]);
    check("pos select", posOut[c], posSel[c]);
    check("neg select", negOut[c], negSel[c]);
  endtask : setup

  // One single-shot comparison started by software or by an event
  task automatic shot(input int c, input bit byEvent);
    int   cnt;
    int   nS;
    logic v;
    logic f;
    v  = 1'($random(seed));
    nS = samples(fltLen[c]);
    @(posedge ref_clk);
    irqFlagClear   <= 2'h3;
    analogLevel[c] <= v;
    @(posedge ref_clk);
    irqFlagClear       <= 2'h0;
    startComparison[c] <= !byEvent;
    startEvent[c]      <= byEvent;
    @(posedge ref_clk);
    startComparison <= 2'h0;
    startEvent      <= 2'h0;
    repeat (2) @(negedge ref_clk);
    check("ready at start", compReady[c], byEvent);
    check("clock request", clockRequest, 1'b1);
    check("power up", compPowerUp[c], 1'b1);
    cnt = 1;
    do begin
      @(negedge ref_clk);
      cnt++;
    end while ((byEvent ? irqFlag[c] : compReady[c]) !== 1'b1 && cnt < 60);
    check("latency", cnt == S + nS + 1 || cnt == S + nS + 2, 1'b1);
    @(negedge ref_clk);
    f = expFlag(int'(irqSel[c]), expState[c], v);
    check("state", compState[c], v);
    check("ready", compReady[c], 1'b1);
    check("flag", irqFlag[c], f);
    check("request", irqRequest, f & irqEnable[c]);
    check("event", compEvent[c], v & eventOutEnable[c]);
    expState[c] = v;
    repeat (3) @(negedge ref_clk);
    check("powered down", compPowerUp[c], 1'b0);
  endtask : shot

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Cut a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles >= LIMIT) begin
      failCount++;
      completeRun();
    end
  end

  initial begin
    seed = 32'hA46990FB;
    {sys_rst, moduleEnable} = 2'h3;
    {sleepMode, wakeupEnable} = 2'h0;
    {compEnable, singleShot, runInStandby, startComparison} = 8'h00;
    {eventStartEnable, startEvent, eventOutEnable, irqEnable} = 8'h00;
    {irqFlagClear, analogLevel, expState} = 6'h00;
    {posSel, negSel} = '0;
    for (int i = 0; i < 2; i++) begin
      irqSel[i] = ACC_IRQ_TOGGLE;
      fltLen[i] = ACC_FLT_NONE;
    end
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    check("reset outputs", {compState, compReady, compEvent, irqFlag, compPowerUp,
                            irqRequest, clockRequest}, 0);
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Every interrupt condition and filter length, then event starts
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 4; k++) begin
        setup(c, 1'b1, k, k, 1'b0);
        shot(c, 1'b0);
      end
      @(posedge ref_clk);
      startEvent[c] <= 1'b1;
      @(posedge ref_clk);
      startEvent[c]       <= 1'b0;
      eventStartEnable[c] <= 1'b1;
      repeat (2) @(negedge ref_clk);
      check("event refused", compPowerUp[c], 1'b0);
      shot(c, 1'b1);
    end
    // Continuous mode with a three-sample majority filter
    @(posedge ref_clk);
    analogLevel[0] <= !expState[0];
    setup(0, 1'b0, 0, 1, 1'b1);
    waitState(0, !expState[0], n);
    check("first result", n > S - 3 && n < 60, 1'b1);
    check("continuous flags", {compReady[0], irqFlag[0]}, 2'h3);
    expState[0] = !expState[0];
    @(posedge ref_clk);
    irqFlagClear   <= 2'h3;
    analogLevel[0] <= !expState[0];
    @(posedge ref_clk);
    irqFlagClear   <= 2'h0;
    analogLevel[0] <= expState[0];
    repeat (8) @(negedge ref_clk);
    check("glitch filtered", {compState[0], irqFlag[0]}, {expState[0], 1'b0});
    @(posedge ref_clk);
    analogLevel[0] <= !expState[0];
    waitState(0, !expState[0], n);
    check("continuous follow", n < 10, 1'b1);
    check("toggle flag", irqFlag[0], 1'b1);
    expState[0] = !expState[0];
    // A selection change while enabled must not reach the core
    @(posedge ref_clk);
    posSel[0] <= ~posSel[0];
    repeat (2) @(negedge ref_clk);
    check("locked select", posOut[0] ^ posSel[0], 2'h3);
    // Module-level disable stops the comparator but not its enable bit
    @(posedge ref_clk);
    moduleEnable   <= 1'b0;
    analogLevel[0] <= !expState[0];
    repeat (8) @(negedge ref_clk);
    check("module off", {compPowerUp[0], compState[0]}, {1'b0, expState[0]});
    @(posedge ref_clk);
    moduleEnable <= 1'b1;
    waitState(0, !expState[0], n);
    check("restart", n > S - 3 && n < 60, 1'b1);
    expState[0] = !expState[0];
    // Sleep: continuous changes and event starts borrow the clock
    setup(0, 1'b0, 0, 0, 1'b1);
    setup(1, 1'b1, 3, 0, 1'b1);
    repeat (20) @(posedge ref_clk);
    sleepMode <= 1'b1;
    repeat (6) @(negedge ref_clk);
    check("clock gated", clockRequest, 1'b0);
    @(posedge ref_clk);
    analogLevel[0] <= !expState[0];
    waitState(0, !expState[0], n);
    check("sleep change", n < 10, 1'b1);
    expState[0] = !expState[0];
    repeat (6) @(negedge ref_clk);
    check("clock gated again", clockRequest, 1'b0);
    shot(1, 1'b1);
    check("clock off", clockRequest, 1'b0);
    @(posedge ref_clk);
    wakeupEnable <= 1'b1;
    repeat (2) @(negedge ref_clk);
    check("wake clock", clockRequest, 1'b1);
    completeRun();
  end
endmodule : testbench
